/* rtl/rca_core.sv */
// Purpose: Real-time clock with prescaler, counter, alarm and backup words.
// Assumes: Time-base sources are slow pins sampled in clk_i (10 MHz).
// Notes:   Sources are edge-detected after a two-stage synchroniser.
// Behaviour
// - A 32-bit loadable counter raises an alarm on compare match.
// - Counter advances on ticks of a 20-bit prescaler, default one second.
// - Time base is low-speed, low-power, or fast external clock over 128.
// - Separate alarm and periodic interrupt outputs.
// - Counters run continuously once started without software help.
// - A 512 Hz reference output is derived from the time-base clock.
// - Ten 16-bit backup words keep user data while on battery.
`timescale 1ns/1ns
`include "rca_map.svh"
module rca_core #(
    parameter logic [19:0] PRESCALE_RST = `RCA_PRESCALE_RST,
    parameter int          NUM_BKP      = `RCA_NUM_BACKUP
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 lowspeed_clk_i,
    input  wire logic                 lowpower_clk_i,
    input  wire logic                 fast_external_clock_i,
    input  wire rca_pkg::rca_sel_t    src_sel_i,
    input  wire logic                 run_i,
    input  wire logic                 cnt_load_i,
    input  wire logic [31:0]          cnt_val_i,
    input  wire logic                 pre_load_i,
    input  wire logic [19:0]          pre_val_i,
    input  wire logic                 cmp_load_i,
    input  wire logic [31:0]          cmp_val_i,
    input  wire rca_pkg::rca_flags_t  flag_clr_i,
    input  wire logic                 cal_en_i,
    input  wire rca_pkg::rca_bkp_wr_t bkp_wr_i,
    output logic [31:0]               count_o,
    output rca_pkg::rca_flags_t       flags_o,
    output logic                      cal_out_o,
    output logic [NUM_BKP*16-1:0]     bkp_o
);
    logic [1:0]  rst_sync_ff;
    wire         rst_n = rst_sync_ff[1];
    logic [2:0]  sync1_ff;
    logic [2:0]  sync2_ff;
    logic [2:0]  prev_ff;
    logic [6:0]  fdiv_ff;
    logic        fdiv_edge_ff;
    logic [19:0] pre_rld_ff;
    logic [19:0] pre_cnt_ff;
    logic [31:0] cnt_ff;
    logic [31:0] cmp_ff;
    rca_pkg::rca_flags_t flags_ff;
    logic [5:0]  cal_div_ff;
    logic        cal_ff;
    wire  [2:0]  rise = sync2_ff & ~prev_ff;
    wire         fast_rise = rise[2];
    wire  [6:0]  nxt_fdiv = fdiv_ff + 7'h01;
    // The fast clock divider wraps every 128 source edges.
    wire         fdiv_wrap = fast_rise && (fdiv_ff == 7'(`RCA_FAST_DIV - 1));
    wire         src_tick = (src_sel_i == `RCA_SEL_LOWSPEED) ? rise[0] :
                            (src_sel_i == `RCA_SEL_LOWPOWER) ? rise[1] :
                            (src_sel_i == `RCA_SEL_FASTDIV)  ? fdiv_edge_ff :
                                                               1'b0;
    wire         pre_wrap = run_i && src_tick && (pre_cnt_ff == 20'h00000);
    wire  [31:0] nxt_cnt = cnt_ff + 32'h1;
    // A load in the tick cycle wins, so a stale count raises no alarm.
    wire         match = pre_wrap && !cnt_load_i && (nxt_cnt == cmp_ff);
    wire  [19:0] nxt_pre = pre_wrap ? pre_rld_ff : pre_cnt_ff - 20'h1;
    wire         cal_wrap = src_tick && (cal_div_ff == 6'h00);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    // Detectors reset low to match an idle source, avoiding a false edge.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end else begin
            sync1_ff <= {fast_external_clock_i, lowpower_clk_i,
                         lowspeed_clk_i};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fdiv_ff      <= 7'h00;
            fdiv_edge_ff <= 1'b0;
        end else begin
            if (fast_rise) begin
                fdiv_ff <= nxt_fdiv;
            end
            fdiv_edge_ff <= fdiv_wrap;
        end
    end

    // Prescaler counts down and reloads, so a reload of N divides by N+1.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_rld_ff <= PRESCALE_RST;
            pre_cnt_ff <= PRESCALE_RST;
        end else if (pre_load_i) begin
            pre_rld_ff <= pre_val_i;
            pre_cnt_ff <= pre_val_i;
        end else if (run_i && src_tick) begin
            pre_cnt_ff <= nxt_pre;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
        end else if (cnt_load_i) begin
            cnt_ff <= cnt_val_i;
        end else if (pre_wrap) begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmp_ff <= 32'hffffffff;
        end else if (cmp_load_i) begin
            cmp_ff <= cmp_val_i;
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff.second <= pre_wrap | (flags_ff.second &
                               ~flag_clr_i.second);
            flags_ff.alarm  <= match | (flags_ff.alarm &
                               ~flag_clr_i.alarm);
        end
    end

    // Reference output toggles every 32 time-base edges: 512 Hz at 32.768 kHz.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cal_div_ff <= `RCA_CAL_DIV_RST;
            cal_ff     <= 1'b0;
        end else begin
            if (src_tick) begin
                cal_div_ff <= cal_wrap ? `RCA_CAL_DIV_RST : cal_div_ff - 6'h01;
            end
            cal_ff <= cal_en_i & (cal_wrap ? ~cal_ff : cal_ff);
        end
    end

    rca_backup #(
        .NUM (NUM_BKP)
    ) u_backup (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .wr_i    (bkp_wr_i),
        .data_o  (bkp_o)
    );

    assign count_o   = cnt_ff;
    assign flags_o   = flags_ff;
    assign cal_out_o = cal_ff;

    AST_CNT_STEP: assert property (@(posedge clk_i) disable iff (!rst_n)
        pre_wrap && !cnt_load_i |=> cnt_ff == $past(cnt_ff) + 32'h1)
        else $error("Counter did not step on prescaler wrap.");
    AST_CNT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
        !pre_wrap && !cnt_load_i |=> $stable(cnt_ff))
        else $error("Counter moved without a tick.");
    AST_ALARM_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
        match |=> flags_ff.alarm)
        else $error("Alarm flag missed on match.");
    AST_ALARM_CAUSE: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        $rose(flags_ff.alarm) |-> $past(match))
        else $error("Alarm flag rose without a match.");
    AST_SEC_STICKY: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        flags_ff.second && !flag_clr_i.second |=> flags_ff.second)
        else $error("Periodic flag dropped without a clear.");
    AST_PRE_RELOAD: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        pre_wrap && !pre_load_i |=> pre_cnt_ff == pre_rld_ff)
        else $error("Prescaler did not reload on wrap.");
    AST_FDIV_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n)
        fdiv_wrap |=> fdiv_edge_ff && fdiv_ff == 7'h00)
        else $error("Fast divider did not wrap at 128.");
    AST_CAL_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
        !cal_en_i |=> !cal_ff)
        else $error("Reference output active while disabled.");
    AST_BKP_WR: assert property (@(posedge clk_i) disable iff (!rst_n)
        bkp_wr_i.we && bkp_wr_i.idx == 4'h0 |=> bkp_o[15:0] ==
        $past(bkp_wr_i.data))
        else $error("Backup word 0 not written.");
    AST_SEC_SET: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        pre_wrap |=> flags_ff.second)
        else $error("Periodic flag missed on prescaler wrap.");
    AST_ALARM_STICKY: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        flags_ff.alarm && !flag_clr_i.alarm |=> flags_ff.alarm)
        else $error("Alarm flag dropped without a clear.");
    AST_CNT_LOAD: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        cnt_load_i |=> cnt_ff == $past(cnt_val_i))
        else $error("Counter did not take the loaded value.");
    AST_CAL_TOGGLE: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        cal_en_i && cal_wrap |=> cal_ff != $past(cal_ff))
        else $error("Reference output did not toggle on divider wrap.");
    // Only words that exist may change; higher indices are dropped.
    AST_BKP_IGNORE: assert property (@(posedge clk_i)
        disable iff (!rst_n)
        bkp_wr_i.we && bkp_wr_i.idx >= NUM_BKP |=> $stable(bkp_o))
        else $error("Write to a missing backup word changed storage.");
    COV_ALARM: cover property (@(posedge clk_i) match);
    COV_WRAP: cover property (@(posedge clk_i) pre_wrap);
    COV_CLR_SET: cover property (@(posedge clk_i)
        flag_clr_i.second && pre_wrap);
    COV_CAL: cover property (@(posedge clk_i) $rose(cal_ff));
endmodule : rca_core

/* rtl/rca_map.svh */
// Purpose: Constants of the real-time clock block.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef RCA_MAP_SVH
`define RCA_MAP_SVH
`define RCA_PRESCALE_RST   20'h07fff
`define RCA_SEL_LOWSPEED   2'h0
`define RCA_SEL_LOWPOWER   2'h1
`define RCA_SEL_FASTDIV    2'h2
`define RCA_FAST_DIV       8'h80
`define RCA_CAL_DIV_RST    6'h1f
`define RCA_NUM_BACKUP     10
`endif

/* rtl/rca_pkg.sv */
// Purpose: Types of the real-time clock block.
// Assumes: Nothing.
// Notes:   Nothing is imported by users.
package rca_pkg;
    typedef logic [1:0] rca_sel_t;
    typedef struct packed {
        logic        we;
        logic [3:0]  idx;
        logic [15:0] data;
    } rca_bkp_wr_t;
    typedef struct packed {
        logic alarm;
        logic second;
    } rca_flags_t;
endpackage : rca_pkg

/* rtl/rca_backup.sv */
// Purpose: Ten 16-bit backup words.
// Assumes: The domain stays powered from the backup battery supply.
// Notes:   Contents change only on a write strobe, or on reset, which clears them.
`timescale 1ns/1ns
`include "rca_map.svh"
module rca_backup #(
    parameter int NUM = `RCA_NUM_BACKUP
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire rca_pkg::rca_bkp_wr_t wr_i,
    output logic [NUM*16-1:0]         data_o
);
    genvar g;
    for (g = 0; g < NUM; g++) begin : g_word
        logic [15:0] word_ff;
        wire         hit = wr_i.we && (wr_i.idx == 4'(g));
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                word_ff <= 16'h0000;
            end else if (hit) begin
                word_ff <= wr_i.data;
            end
        end
        assign data_o[g*16 +: 16] = word_ff;
    end
endmodule : rca_backup

/* tb/rtc_counter_alarm_backup_tb.sv */
// Purpose: Self-checking bench of the real-time clock core.
// Assumes: All three source pins toggle together; src_sel_i picks one.
// Notes:   The prescaler is loaded small so that ticks come quickly.
`timescale 1ns/1ns
`include "rca_map.svh"
module rtc_counter_alarm_backup_tb;
    logic                 clk_i, rst_n_i, run_i, cal_en_i;
    logic                 cnt_load_i, pre_load_i, cmp_load_i, cal_out_o;
    logic [2:0]           pin;
    rca_pkg::rca_sel_t    src_sel_i;
    logic [31:0]          cnt_val_i, cmp_val_i, count_o, exp_cnt, base;
    logic [19:0]          pre_val_i;
    rca_pkg::rca_flags_t  flag_clr_i, flags_o;
    rca_pkg::rca_bkp_wr_t bkp_wr_i;
    logic [159:0]         bkp_o, bkp_m;
    int                   num_errors, comparisons, cycles, tgl, nticks;

    // 512 Hz from 32.768 kHz: the output flips every 32 time-base ticks.
    localparam int CAL_HALF = 32768 / 512 / 2;

    rca_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .lowspeed_clk_i(pin[0]), .lowpower_clk_i(pin[1]),
        .fast_external_clock_i(pin[2]), .src_sel_i(src_sel_i),
        .run_i(run_i), .cnt_load_i(cnt_load_i), .cnt_val_i(cnt_val_i),
        .pre_load_i(pre_load_i), .pre_val_i(pre_val_i),
        .cmp_load_i(cmp_load_i), .cmp_val_i(cmp_val_i),
        .flag_clr_i(flag_clr_i), .cal_en_i(cal_en_i), .bkp_wr_i(bkp_wr_i),
        .count_o(count_o), .flags_o(flags_o), .cal_out_o(cal_out_o),
        .bkp_o(bkp_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Cal edges are counted by level change, so only deltas are used.
    always @(cal_out_o) tgl++;

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] ticks(input int n, input int div);
        return 32'(n / div);
    endfunction : ticks

    // Flips of the reference output between two totals of time-base ticks.
    function automatic int cal_flips(input int t0, input int t1);
        return t1 / CAL_HALF - t0 / CAL_HALF;
    endfunction : cal_flips

    // Each edge is held 4 cycles high and 4 low, beyond the 4-cycle path.
    task automatic edges(input int n);
        repeat (n) begin
            pin = 3'h7;
            repeat (4) @(negedge clk_i);
            pin = 3'h0;
            repeat (4) @(negedge clk_i);
        end
    endtask : edges

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    initial begin
        {rst_n_i, run_i, cal_en_i, cnt_load_i, pre_load_i, cmp_load_i} = '0;
        {pin, src_sel_i, cnt_val_i, cmp_val_i, pre_val_i} = '0;
        flag_clr_i = '0;
        bkp_wr_i = '0;
        bkp_m = '0;
        nticks = 0;
        void'($urandom(3922));
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(count_o, 160'h0);
        chk(flags_o, 160'h0);
        chk(cal_out_o, 160'h0);
        chk(bkp_o, 160'h0);
        cal_en_i = 1'b1;
        $display("reset test done");
        // Words 10 to 15 do not exist, so those writes must leave no trace.
        for (int i = 0; i < 16; i++) begin
            bkp_wr_i = '{1'b1, 4'(i), 16'($urandom)};
            if (i < 10) bkp_m[16*i +: 16] = bkp_wr_i.data;
            @(negedge clk_i);
        end
        bkp_wr_i.we = 1'b0;
        @(negedge clk_i);
        chk(bkp_o, bkp_m);
        $display("backup test done");
        base = $urandom;
        exp_cnt = base;
        {cnt_val_i, cmp_val_i, pre_val_i} = {base, base + 32'h3, 20'h0};
        {cnt_load_i, cmp_load_i, pre_load_i} = 3'h7;
        @(negedge clk_i);
        {cnt_load_i, cmp_load_i, pre_load_i} = 3'h0;
        chk(count_o, exp_cnt);
        run_i = 1'b1;
        for (int s = 0; s < 4; s++) begin
            src_sel_i = 2'(s);
            flag_clr_i = 2'h3;
            @(negedge clk_i);
            flag_clr_i = 2'h0;
            chk(flags_o, 160'h0);
            edges((s == 2) ? 256 : 2);
            if (s != 3) exp_cnt = exp_cnt + 32'h2;
            if (s != 3) nticks = nticks + 2;
            chk(count_o, exp_cnt);
            chk(flags_o.second, (s != 3));
            chk(flags_o.alarm, (s == 1));
        end
        $display("source and alarm test done");
        src_sel_i = `RCA_SEL_LOWSPEED;
        // A tick that meets a clear still sets the flag, so no event is lost.
        flag_clr_i = 2'h3;
        pin = 3'h7;
        repeat (3) @(negedge clk_i);
        flag_clr_i = 2'h0;
        pin = 3'h0;
        exp_cnt = exp_cnt + 32'h1;
        nticks = nticks + 1;
        chk(flags_o.second, 1'b1);
        chk(count_o, exp_cnt);
        repeat (4) @(negedge clk_i);
        $display("clear against tick test done");
        pre_val_i = 20'h3;
        pre_load_i = 1'b1;
        @(negedge clk_i);
        pre_load_i = 1'b0;
        tgl = 0;
        // Eight edges at divide-by-four give two ticks whatever the phase.
        edges(8);
        exp_cnt = exp_cnt + ticks(8, 4);
        chk(count_o, exp_cnt);
        edges(56);
        exp_cnt = exp_cnt + ticks(56, 4);
        chk(count_o, exp_cnt);
        chk(tgl, cal_flips(nticks, nticks + 64));
        $display("prescaler and calibration test done");
        end_sim();
    end
endmodule : rtc_counter_alarm_backup_tb
